// ---- pkg/lite_wdg_pkg.sv ----
// Constants for the lite timebase and watchdog block.
// Assumes one 40 MHz bus clock and an 8 MHz oscillator rate made by a divider.
package lite_wdg_pkg;

  // ----------------------------------------------------------------
  // Clock rates and times
  // ----------------------------------------------------------------
  localparam int unsigned PCLK_FREQ_HZ  = 40_000_000;
  localparam int unsigned OSC_FREQ_HZ   = 8_000_000;
  localparam int unsigned OSC_DIV       = PCLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam logic [2:0]  OSC_DIV_LAST  = 3'(OSC_DIV - 1);
  localparam int unsigned TB_PERIOD_MS  = 1;
  localparam int unsigned DOG_PERIOD_MS = 2;
  // Timebase wraps per watchdog period
  localparam int unsigned DOG_WRAPS     = DOG_PERIOD_MS / TB_PERIOD_MS;
  // Terminal count of the 13-bit timebase, one wrap per TB_PERIOD_MS
  localparam logic [12:0] TB_TERMINAL   = 13'h1F39;
  localparam logic [12:0] TB_RESET      = 13'h0000;
  // Oscillator clocks of hold-off after a wake from halt
  localparam logic [6:0]  WAKE_CLOCKS   = 7'h40;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offset is a register index; byte address is four times it
  localparam logic [7:0]  CSR_INDEX     = 8'h0B;
  localparam logic [7:0]  CSR_ADDR      = 8'(CSR_INDEX * 4);

  // timer_ctrl_status field positions
  localparam int unsigned BIT_DELAY     = 0;
  localparam int unsigned BIT_ENABLE    = 1;
  localparam int unsigned BIT_FORCE     = 2;
  localparam int unsigned BIT_TICK_FLAG = 3;
  localparam int unsigned BIT_TICK_IE   = 4;
  localparam int unsigned BIT_PER_DBL   = 5;

  // Reset values
  localparam logic        CTRL_RESET    = 1'b0;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // Halt handling states
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_HALTED,
    PWR_WAKING
  } pwr_state_e;

endpackage

// ---- src/lite_timebase_watchdog.sv ----
// Lite timebase (13-bit free counter, 1/2 ms tick) and watchdog with APB access.
// Assumes all inputs synchronous to pclk; option inputs are static straps.
// The system reset request goes out; presetn then comes back to this block,
// while the force/status bit is kept by the separate lvd_rst_n domain.
//
// Contract
// - Hidden 13-bit timebase counter starts at zero, counts every oscillator clock.
// - Overflow event when the counter wraps from 1F39h to zero, 1 ms.
// - Period double select makes the tick interval 2 ms.
// - Overflow sets tick flag; interrupt raised while tick interrupt enable set.
// - Reading the control/status register clears the tick flag.
// - Enabled watchdog resets after its 2 ms period unless refreshed.
// - Software sets delay bit regularly; hardware clears it each period end.
// - Periods count from reset regardless of enable; late enable resets at once.
// - Force reset: enable first, then set force bit; reset follows.
// - Force bit records a watchdog reset; read lets it be cleared.
// - Force bit still set when watchdog enabled gives an immediate reset.
// - Hardware watchdog option keeps watchdog active, ignores enable bit.
// - Reset-on-halt option turns a halt into a watchdog reset.
// - Otherwise halt stops oscillator and timebase; no watchdog reset meanwhile.
// - Wake by interrupt resumes counting 64 clocks later; reset disables.
// - Force bit cleared by hardware only on detector reset, else software.
// - Register index 0B: delay bit 0, enable bit 1, force bit 2.
//
// Decided for this implementation: the register offsets and register access over APB.
module lite_timebase_watchdog
  import lite_wdg_pkg::*;
(
  // Clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        lvd_rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Option straps
  input  wire logic        hw_dog_opt,
  input  wire logic        halt_reset_opt,
  // Core power events
  input  wire logic        halt_req,
  input  wire logic        ext_wake,
  // Requests out
  output logic             tick_irq,
  output logic             dog_rst_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0]  osc_div_ff;
  logic [12:0] tb_cnt_ff;
  logic        phase_ff;
  logic [6:0]  wake_cnt_ff;
  pwr_state_e  pwr_ff;
  logic        period_double_sel_ff;
  logic        tick_irq_en_ff;
  logic        tick_flag_ff;
  logic        dog_enable_ff;
  logic        dog_delay_refresh_ff;
  logic        dog_force_status_ff;
  logic        status_read_ff;
  logic        expired_ff;
  logic        active_q_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        tick_irq_ff;
  logic        dog_rst_req_ff;

  logic [2:0]  nxt_osc_div;
  logic [12:0] nxt_tb_cnt;
  logic [6:0]  nxt_wake_cnt;
  pwr_state_e  nxt_pwr;

  // Packed view of the control/status register
  function automatic logic [31:0] csr_image(input logic dbl, input logic ie, input logic flg,
                                            input logic frc, input logic en, input logic dly);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[BIT_PER_DBL]   = dbl;
    v[BIT_TICK_IE]   = ie;
    v[BIT_TICK_FLAG] = flg;
    v[BIT_FORCE]     = frc;
    v[BIT_ENABLE]    = en;
    v[BIT_DELAY]     = dly;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Access is taken one cycle into the access phase; pready follows next edge
  wire acc_fire  = psel & penable & ~pready_ff;
  wire csr_hit   = (paddr == CSR_ADDR);
  wire csr_rd    = acc_fire & ~pwrite & csr_hit;
  wire csr_wr    = acc_fire & pwrite & csr_hit;
  wire wr_dly    = pwdata[BIT_DELAY];
  wire wr_en     = pwdata[BIT_ENABLE];
  wire wr_frc    = pwdata[BIT_FORCE];
  wire [31:0] csr_now = csr_image(period_double_sel_ff, tick_irq_en_ff, tick_flag_ff,
                                  dog_force_status_ff, dog_enable_ff, dog_delay_refresh_ff);

  // ----------------------------------------------------------------
  // Oscillator rate and timebase
  // ----------------------------------------------------------------
  // Oscillator stops in halt; waking keeps it running but holds the counter
  wire osc_run   = (pwr_ff != PWR_HALTED);
  wire osc_en    = osc_run & (osc_div_ff == OSC_DIV_LAST);
  wire tb_en     = osc_en & (pwr_ff == PWR_RUN);
  wire tb_wrap   = tb_en & (tb_cnt_ff == TB_TERMINAL);
  wire tick_evt  = tb_wrap & (~period_double_sel_ff | phase_ff);
  // Watchdog period spans DOG_WRAPS wraps, counted from reset always
  wire dog_end   = tb_wrap & phase_ff;

  // Divider and counter next values
  assign nxt_osc_div = (!osc_run || osc_div_ff == OSC_DIV_LAST) ? 3'h0 : osc_div_ff + 3'h1;
  assign nxt_tb_cnt  = tb_wrap ? TB_RESET : (tb_en ? tb_cnt_ff + 13'h0001 : tb_cnt_ff);

  // ----------------------------------------------------------------
  // Watchdog decisions
  // ----------------------------------------------------------------
  wire dog_active = hw_dog_opt | dog_enable_ff;
  wire act_rise   = dog_active & ~active_q_ff;
  // Timeout with no refresh pending
  wire expire     = dog_end & ~dog_delay_refresh_ff;
  wire rst_expire = expire & dog_active;
  // Late enable after a lapsed period, or with a stale force flag
  wire rst_enable = act_rise & (expired_ff | dog_force_status_ff);
  // Forced reset needs the watchdog already running
  wire rst_force  = csr_wr & wr_frc & dog_active;
  wire rst_halt   = halt_req & halt_reset_opt & (pwr_ff == PWR_RUN);
  wire rst_any    = rst_expire | rst_enable | rst_force | rst_halt;

  // ----------------------------------------------------------------
  // Halt handling
  // ----------------------------------------------------------------
  // Halt freezes the oscillator and timebase until an external wake; a reset simply restarts
  always_comb begin
    nxt_pwr      = pwr_ff;
    nxt_wake_cnt = wake_cnt_ff;
    case (pwr_ff)
      PWR_RUN: begin
        if (halt_req && !halt_reset_opt) begin
          nxt_pwr = PWR_HALTED;
        end
      end
      PWR_HALTED: begin
        if (ext_wake) begin
          nxt_pwr      = PWR_WAKING;
          nxt_wake_cnt = WAKE_CLOCKS;
        end
      end
      PWR_WAKING: begin
        if (osc_en) begin
          nxt_wake_cnt = wake_cnt_ff - 7'h01;
          if (wake_cnt_ff == 7'h01) begin
            nxt_pwr = PWR_RUN;
          end
        end
      end
      default: begin
        nxt_pwr = PWR_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Timebase registers
  // ----------------------------------------------------------------
  // Counter, divider and wrap phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_div_ff  <= 3'h0;
      tb_cnt_ff   <= TB_RESET;
      phase_ff    <= 1'b0;
      pwr_ff      <= PWR_RUN;
      wake_cnt_ff <= 7'h00;
    end else begin
      osc_div_ff  <= nxt_osc_div;
      tb_cnt_ff   <= nxt_tb_cnt;
      phase_ff    <= tb_wrap ? ~phase_ff : phase_ff;
      pwr_ff      <= nxt_pwr;
      wake_cnt_ff <= nxt_wake_cnt;
    end
  end

  // Tick flag: a new overflow wins over a clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_flag_ff <= CTRL_RESET;
    end else if (tick_evt) begin
      tick_flag_ff <= 1'b1;
    end else if (csr_rd) begin
      tick_flag_ff <= 1'b0;
    end
  end

  // Interrupt level follows flag and enable, registered for a clean output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_irq_ff <= 1'b0;
    end else begin
      tick_irq_ff <= (tick_flag_ff | tick_evt) & tick_irq_en_ff;
    end
  end

  // ----------------------------------------------------------------
  // Software control bits
  // ----------------------------------------------------------------
  // Plain read/write bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_double_sel_ff <= CTRL_RESET;
      tick_irq_en_ff       <= CTRL_RESET;
      dog_enable_ff        <= CTRL_RESET;
    end else if (csr_wr) begin
      period_double_sel_ff <= pwdata[BIT_PER_DBL];
      tick_irq_en_ff       <= pwdata[BIT_TICK_IE];
      dog_enable_ff        <= wr_en;
    end
  end

  // Delay bit: software only sets it, period end clears it; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_delay_refresh_ff <= CTRL_RESET;
    end else if (csr_wr && wr_dly) begin
      dog_delay_refresh_ff <= 1'b1;
    end else if (dog_end) begin
      dog_delay_refresh_ff <= 1'b0;
    end
  end

  // Lapsed period seen while disabled; a refresh cancels it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expired_ff <= 1'b0;
    end else if (csr_wr && wr_dly) begin
      expired_ff <= 1'b0;
    end else if (expire) begin
      expired_ff <= 1'b1;
    end
  end

  // Previous active level for enable edges, hardware option included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q_ff <= 1'b0;
    end else begin
      active_q_ff <= dog_active;
    end
  end

  // ----------------------------------------------------------------
  // Force/status bit
  // ----------------------------------------------------------------
  // Survives presetn so the cause of a watchdog reset stays visible;
  // only the detector reset clears it in hardware
  always_ff @(posedge pclk or negedge lvd_rst_n) begin
    if (!lvd_rst_n) begin
      dog_force_status_ff <= 1'b0;
    end else if (rst_any) begin
      dog_force_status_ff <= 1'b1;
    end else if (csr_wr && !wr_frc && status_read_ff) begin
      dog_force_status_ff <= 1'b0;
    end
  end

  // A read must precede the clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_read_ff <= 1'b0;
    end else if (csr_rd) begin
      status_read_ff <= 1'b1;
    end else if (csr_wr) begin
      status_read_ff <= 1'b0;
    end
  end

  // One-cycle reset request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_rst_req_ff <= 1'b0;
    end else begin
      dog_rst_req_ff <= rst_any;
    end
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // One wait state buys a registered read data path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= RDATA_RESET;
    end else begin
      pready_ff  <= acc_fire;
      pslverr_ff <= acc_fire & ~csr_hit;
      if (acc_fire) begin
        prdata_ff <= (csr_hit && !pwrite) ? csr_now : RDATA_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign tick_irq    = tick_irq_ff;
  assign dog_rst_req = dog_rst_req_ff;

endmodule

// ---- sim/lite_wdg_chk.sv ----
// Port assertions for the lite timebase and watchdog block.
// Assumes an APB master that holds each request until pready; bound below.
module lite_wdg_chk
  import lite_wdg_pkg::*;
(
  // Clock and resets
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        lvd_rst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Straps, events and requests
  input wire logic        hw_dog_opt,
  input wire logic        halt_reset_opt,
  input wire logic        halt_req,
  input wire logic        ext_wake,
  input wire logic        tick_irq,
  input wire logic        dog_rst_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  // Access cycle before the answer, and a hit on the one register
  wire take_acc = psel && penable && !pready;
  wire csr_hit  = paddr == CSR_ADDR;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_answer; take_acc |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no pready after access");
  property p_one_ready; pready |=> !pready; endproperty
  a_one_ready: assert property (p_one_ready) else $error("pready held too long");
  property p_refuse; take_acc && !csr_hit |=> pslverr && prdata == 32'h0000_0000; endproperty
  a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
  property p_mapped; take_acc && csr_hit |=> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_rd_width; pready && !pwrite |-> prdata[31:6] == 26'h000_0000; endproperty
  a_rd_width: assert property (p_rd_width) else $error("unused read bits set");
  // Read clear lands one cycle late because the request is registered
  property p_tick_clear; take_acc && csr_hit && !pwrite && tick_irq |-> ##[2:3] !tick_irq; endproperty
  a_tick_clear: assert property (p_tick_clear) else $error("read did not drop tick irq");
  property p_rst_single; dog_rst_req |=> !dog_rst_req; endproperty
  a_rst_single: assert property (p_rst_single) else $error("reset request too long");
  property p_halt_rst; halt_req && halt_reset_opt |-> ##[1:4] dog_rst_req; endproperty
  a_halt_rst: assert property (p_halt_rst) else $error("halt gave no reset");
  property p_halt_quiet; halt_req && !halt_reset_opt |=> !dog_rst_req [*8]; endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("reset while halted");
  property p_rel_quiet; $rose(presetn) |-> !pready && !dog_rst_req; endproperty
  a_rel_quiet: assert property (p_rel_quiet) else $error("output busy at release");
endmodule

bind lite_timebase_watchdog lite_wdg_chk u_chk (
  .pclk(pclk), .presetn(presetn), .lvd_rst_n(lvd_rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .hw_dog_opt(hw_dog_opt), .halt_reset_opt(halt_reset_opt),
  .halt_req(halt_req), .ext_wake(ext_wake), .tick_irq(tick_irq), .dog_rst_req(dog_rst_req)
);

// ---- sim/lite_timebase_watchdog_tb_top.sv ----
// Self-checking bench for the lite timebase and watchdog block.
// Assumes the checker binds itself in; one 40 MHz clock drives everything.
module lite_timebase_watchdog_tb_top
  import lite_wdg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        lvd_rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hw_dog_opt;
  logic        halt_reset_opt;
  logic        halt_req;
  logic        ext_wake;
  logic        tick_irq;
  logic        dog_rst_req;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          num_checks;
  int          cyc;

  typedef struct packed {
    logic [31:0] wd;
    logic [31:0] exp;
  } row_s;
  // Write, then the value read back; bit 3 and bits 7:6 never stick
  row_s rows [6] = '{
    '{32'h0000_0030, 32'h0000_0030},
    '{32'h0000_00C8, 32'h0000_0000},
    '{32'h0000_0001, 32'h0000_0001},
    '{32'h0000_0000, 32'h0000_0001},
    '{32'h0000_0004, 32'h0000_0001},
    '{32'h0000_0003, 32'h0000_0003}
  };

  lite_timebase_watchdog uut (
    .pclk(pclk), .presetn(presetn), .lvd_rst_n(lvd_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_dog_opt(hw_dog_opt), .halt_reset_opt(halt_reset_opt),
    .halt_req(halt_req), .ext_wake(ext_wake), .tick_irq(tick_irq), .dog_rst_req(dog_rst_req)
  );

  // Clock, and edges counted since the last reset release
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    // Idle edge first, so psel is never lowered and raised in one step
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk("apb pready", 32'h0000_0001, 32'(pready));
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_csr(input logic [31:0] v);
    apb(1'b1, CSR_ADDR, v);
  endtask

  task automatic rd_csr(input logic [31:0] exp, input string nm);
    apb(1'b0, CSR_ADDR, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask

  // Tick irq (sel high) or reset request; the current sample counts too,
  // since a pulse may already stand in the cycle an access ends
  task automatic wait_sig(input logic sel, input int lim);
    int n;
    n = 0;
    while ((sel ? tick_irq : dog_rst_req) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(sel ? "tick irq" : "reset req", 32'h0000_0001, 32'(sel ? tick_irq : dog_rst_req));
    if ((sel ? tick_irq : dog_rst_req) !== 1'b1) begin
      summarize();
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int h;
    int exp_t;
    int wrap_t;
    presetn        = 1'b0;
    lvd_rst_n      = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 8'h00;
    pwdata         = 32'h0000_0000;
    hw_dog_opt     = 1'b0;
    halt_reset_opt = 1'b0;
    halt_req       = 1'b0;
    ext_wake       = 1'b0;
    errors         = 0;
    num_checks     = 0;
    repeat (6) @(posedge pclk);
    presetn   <= 1'b1;
    lvd_rst_n <= 1'b1;
    @(posedge pclk);
    rd_csr(32'h0000_0000, "csr after reset");
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(er));
    chk("unmapped data", 32'h0000_0000, rd);
    foreach (rows[i]) begin
      wr_csr(rows[i].wd);
      rd_csr(rows[i].exp, "csr readback");
    end
    // Forced reset, enable already set by the last row
    wr_csr(32'h0000_0007);
    wait_sig(1'b0, 20);
    do_reset();
    rd_csr(32'h0000_0004, "force flag");
    // Flag left set: the strap enables the watchdog and it fires at once
    hw_dog_opt <= 1'b1;
    do_reset();
    wait_sig(1'b0, 5);
    hw_dog_opt <= 1'b0;
    do_reset();
    rd_csr(32'h0000_0004, "flag kept");
    wr_csr(32'h0000_0000);
    rd_csr(32'h0000_0000, "flag cleared");
    // Halt turned into a reset by the strap, flag then dropped by detector
    wr_csr(32'h0000_0001);
    halt_reset_opt <= 1'b1;
    halt_req       <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    wait_sig(1'b0, 10);
    halt_reset_opt <= 1'b0;
    do_reset();
    rd_csr(32'h0000_0004, "flag from halt");
    lvd_rst_n <= 1'b0;
    @(posedge pclk);
    lvd_rst_n <= 1'b1;
    @(posedge pclk);
    rd_csr(32'h0000_0000, "flag after detector");
    // Halt freezes the timebase; the wake adds 64 slow ticks of hold-off.
    // One wrap is terminal count plus one oscillator clocks, not a round 1 ms
    wrap_t = (int'(TB_TERMINAL) + 1) * int'(OSC_DIV);
    wr_csr(32'h0000_0030);
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    h = cyc;
    repeat (100) @(posedge pclk);
    ext_wake <= 1'b1;
    @(posedge pclk);
    ext_wake <= 1'b0;
    exp_t = wrap_t + (cyc - h) + int'(WAKE_CLOCKS) * int'(OSC_DIV);
    // Doubled period: the first wrap must stay silent
    while (cyc < exp_t + 20) @(posedge pclk);
    chk("tick at first wrap", 32'h0000_0000, 32'(tick_irq));
    exp_t = exp_t + wrap_t;
    wait_sig(1'b1, 41000);
    chk("tick time", 32'h0000_0001, 32'(cyc > exp_t - 12 && cyc < exp_t + 12));
    rd_csr(32'h0000_0038, "tick flag");
    repeat (3) @(posedge pclk);
    chk("irq after read", 32'h0000_0000, 32'(tick_irq));
    // First period lapsed while disabled at that same wrap, so enabling resets at once
    wr_csr(32'h0000_0002);
    wait_sig(1'b0, 10);
    summarize();
  end
endmodule
